// file: wdsc_cfg.svh
// Timing figures and reset values of the watch display and set control.
`ifndef WDSC_CFG_SVH
`define WDSC_CFG_SVH

`define WDSC_CLK_MHZ 40
`define WDSC_DEB_US 62500
`define WDSC_SEC_US 1000000
`define WDSC_HALF_US 500000
`define WDSC_MD_US 1500000

`define WDSC_RST_MONTH 4'h1
`define WDSC_RST_DATE 5'h01
`define WDSC_RST_HOUR 5'h00
`define WDSC_RST_MINUTE 6'h00
`define WDSC_RST_SECOND 6'h00

`define WDSC_MON_MAX 6'h0C
`define WDSC_HOUR_MAX 6'h17
`define WDSC_MS_MAX 6'h3B
`define WDSC_PM_HOUR 5'h0C

`endif

// file: wdsc_pkg.sv
// Types shared by the watch display and set control.
package wdsc_pkg;

   // Display views and set states, one hot.
   typedef enum logic [6:0] {
      WDSC_V_HM = 7'h01,
      WDSC_V_MD = 7'h02,
      WDSC_V_SEC = 7'h04,
      WDSC_S_MON = 7'h08,
      WDSC_S_DATE = 7'h10,
      WDSC_S_HOUR = 7'h20,
      WDSC_S_MIN = 7'h40
   } wdsc_mode_t;

   // Calendar and time of day, plain binary, hour in 24 hour form.
   typedef struct packed {
      logic [3:0] month;
      logic [4:0] date;
      logic [4:0] hour;
      logic [5:0] minute;
      logic [5:0] second;
   } wdsc_time_t;

   // State of one button debouncer.
   typedef struct packed {
      logic level;
      logic press;
      logic [31:0] cnt;
   } wdsc_deb_t;

endpackage

// file: wdsc_debounce.sv
// Button debouncer that reports a settled level and a press pulse.
`timescale 1ns/10ps
`default_nettype none
`include "wdsc_cfg.svh"

module wdsc_debounce
   import wdsc_pkg::*;
#(
   parameter int unsigned DEB_CYC = `WDSC_DEB_US * `WDSC_CLK_MHZ
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic raw,
   output var logic level,
   output var logic press
);

   wdsc_deb_t st_reg;
   wdsc_deb_t st_next;

   // A new level is accepted only after it has stood for the whole period.
   always_comb
   begin
      st_next = st_reg;
      st_next.press = 1'b0;
      if (raw == st_reg.level)
      begin
         st_next.cnt = 32'h0;
      end
      else if (st_reg.cnt == 32'(DEB_CYC - 1))
      begin
         st_next.cnt = 32'h0;
         st_next.level = raw;
         st_next.press = raw;
      end
      else
      begin
         st_next.cnt = st_reg.cnt + 32'h1;
      end
   end

   // State register.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Outputs come straight from the state flops.
   assign level = st_reg.level;
   assign press = st_reg.press;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_deb_settle: assert property ((raw != level && st_reg.cnt ==
      32'(DEB_CYC - 1)) |=> level == $past(raw))
      else $error("Debounced level did not follow a settled input.");
   a_deb_press: assert property (press |-> level && $past(!level))
      else $error("Press pulse without a rising settled level.");

endmodule
`default_nettype wire

// file: wdsc_top.sv
// Display view selection, set sequence and timekeeping of the watch.
`timescale 1ns/10ps
`default_nettype none
`include "wdsc_cfg.svh"

// Contract
// - Normal display shows hours and minutes continuously.
// - One display press shows month and date about 1.5 s, then returns.
// - Second display press switches to seconds view, held until next press.
// - A display press in seconds view returns to hours and minutes.
// - Set press from normal display enters month set with month flashing.
// - In set states a held display button steps the field at 2 Hz.
// - Each display press in a set state steps the field once.
// - Set press in month set moves to date set.
// - Set press in date set moves to hour set with AM/PM indicator.
// - Set press in hour set moves to minute set with minutes flashing.
// - Stepping minutes halts timekeeping and forces seconds to 00.
// - After minutes were stepped, last set press restarts from 00 seconds.
// - Otherwise the last set press returns without touching seconds.
module wdsc_top
   import wdsc_pkg::*;
#(
   parameter int unsigned DEB_CYC = `WDSC_DEB_US * `WDSC_CLK_MHZ,
   parameter int unsigned SEC_CYC = `WDSC_SEC_US * `WDSC_CLK_MHZ,
   parameter int unsigned HALF_CYC = `WDSC_HALF_US * `WDSC_CLK_MHZ,
   parameter int unsigned MD_CYC = `WDSC_MD_US * `WDSC_CLK_MHZ
)
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic disp_btn,
   input wire logic set_btn,
   output var wdsc_pkg::wdsc_mode_t mode_out,
   output var wdsc_pkg::wdsc_time_t time_out,
   output var logic pm_out,
   output var logic blink_out
);

   import wdsc_pkg::*;

   typedef struct packed {
      wdsc_mode_t mode;
      wdsc_time_t tm;
      logic pm;
      logic blink;
      logic halted;
      logic min_adv;
      logic [31:0] sec_cnt;
      logic [31:0] half_cnt;
      logic [31:0] view_cnt;
   } wdsc_state_t;

   wdsc_state_t st_reg;
   wdsc_state_t st_next;
   logic [1:0] rst_sync_reg;
   logic rst_n;
   logic disp_level;
   logic disp_press;
   logic set_press;
   logic sec_tick;
   logic half_tick;
   logic set_mode;
   logic step;

   // Step a field by one, wrapping from its top value to its bottom value.
   function automatic logic [5:0] wdsc_step(input logic [5:0] v,
      input logic [5:0] lo, input logic [5:0] hi);
      return (v >= hi) ? lo : v + 6'h01;
   endfunction

   // Days of a month; February always has 29, leap years are not tracked.
   function automatic logic [4:0] wdsc_days(input logic [3:0] m);
      unique case (m)
         4'h2: return 5'h1D;
         4'h4, 4'h6, 4'h9, 4'hB: return 5'h1E;
         default: return 5'h1F;
      endcase
   endfunction

   // Reset release through two flops; assertion stays asynchronous.
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_sync_reg <= 2'b00;
      end
      else
      begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // Both buttons pass through the same debouncer.
   wdsc_debounce #(.DEB_CYC(DEB_CYC)) u_deb_disp (
      .mclk(mclk),
      .rst_n(rst_n),
      .raw(disp_btn),
      .level(disp_level),
      .press(disp_press)
   );

   wdsc_debounce #(.DEB_CYC(DEB_CYC)) u_deb_set (
      .mclk(mclk),
      .rst_n(rst_n),
      .raw(set_btn),
      .level(),
      .press(set_press)
   );

   // Tick decode shared by timekeeping, blinking and auto stepping.
   assign sec_tick = !st_reg.halted && st_reg.sec_cnt == 32'(SEC_CYC - 1);
   assign half_tick = st_reg.half_cnt == 32'(HALF_CYC - 1);
   assign set_mode = st_reg.mode inside {WDSC_S_MON, WDSC_S_DATE,
      WDSC_S_HOUR, WDSC_S_MIN};
   assign step = set_mode && (disp_press || (disp_level && half_tick));

   // Next state: dividers, time of day, then view and set handling.
   always_comb
   begin
      st_next = st_reg;
      // The second divider is held at zero while timekeeping is halted.
      if (st_reg.halted || sec_tick)
      begin
         st_next.sec_cnt = 32'h0;
      end
      else
      begin
         st_next.sec_cnt = st_reg.sec_cnt + 32'h1;
      end
      // A fresh press restarts the half second divider, so the first auto
      // step comes a full half second after the single step.
      if (half_tick || disp_press)
      begin
         st_next.half_cnt = 32'h0;
      end
      else
      begin
         st_next.half_cnt = st_reg.half_cnt + 32'h1;
      end
      if (half_tick)
      begin
         st_next.blink = !st_reg.blink;
      end
      // Carry chain of the running clock and calendar.
      if (sec_tick)
      begin
         st_next.tm.second = wdsc_step(st_reg.tm.second, 6'h00, `WDSC_MS_MAX);
         if (st_reg.tm.second == `WDSC_MS_MAX)
         begin
            st_next.tm.minute = wdsc_step(st_reg.tm.minute, 6'h00,
               `WDSC_MS_MAX);
            if (st_reg.tm.minute == `WDSC_MS_MAX)
            begin
               st_next.tm.hour = 5'(wdsc_step({1'b0, st_reg.tm.hour}, 6'h00,
                  `WDSC_HOUR_MAX));
               if (st_reg.tm.hour == 5'(`WDSC_HOUR_MAX))
               begin
                  st_next.tm.date = 5'(wdsc_step({1'b0, st_reg.tm.date},
                     6'h01, {1'b0, wdsc_days(st_reg.tm.month)}));
                  if (st_reg.tm.date == wdsc_days(st_reg.tm.month))
                  begin
                     st_next.tm.month = 4'(wdsc_step({2'b00, st_reg.tm.month},
                        6'h01, `WDSC_MON_MAX));
                  end
               end
            end
         end
      end
      // View and set sequence; edits land after the carry chain.
      unique case (st_reg.mode)
         WDSC_V_HM:
         begin
            if (set_press)
            begin
               st_next.mode = WDSC_S_MON;
            end
            else if (disp_press)
            begin
               st_next.mode = WDSC_V_MD;
               st_next.view_cnt = 32'h0;
            end
         end
         WDSC_V_MD:
         begin
            st_next.view_cnt = st_reg.view_cnt + 32'h1;
            if (disp_press)
            begin
               st_next.mode = WDSC_V_SEC;
            end
            else if (st_reg.view_cnt == 32'(MD_CYC - 1))
            begin
               st_next.mode = WDSC_V_HM;
            end
         end
         WDSC_V_SEC:
         begin
            if (disp_press)
            begin
               st_next.mode = WDSC_V_HM;
            end
         end
         WDSC_S_MON:
         begin
            if (set_press)
            begin
               st_next.mode = WDSC_S_DATE;
            end
            else if (step)
            begin
               st_next.tm.month = 4'(wdsc_step({2'b00, st_reg.tm.month},
                  6'h01, `WDSC_MON_MAX));
               // Keep the date legal for the shorter month.
               if (st_reg.tm.date > wdsc_days(st_next.tm.month))
               begin
                  st_next.tm.date = wdsc_days(st_next.tm.month);
               end
            end
         end
         WDSC_S_DATE:
         begin
            if (set_press)
            begin
               st_next.mode = WDSC_S_HOUR;
            end
            else if (step)
            begin
               st_next.tm.date = 5'(wdsc_step({1'b0, st_reg.tm.date}, 6'h01,
                  {1'b0, wdsc_days(st_reg.tm.month)}));
            end
         end
         WDSC_S_HOUR:
         begin
            if (set_press)
            begin
               st_next.mode = WDSC_S_MIN;
            end
            else if (step)
            begin
               st_next.tm.hour = 5'(wdsc_step({1'b0, st_reg.tm.hour}, 6'h00,
                  `WDSC_HOUR_MAX));
            end
         end
         WDSC_S_MIN:
         begin
            if (set_press)
            begin
               st_next.mode = WDSC_V_HM;
               st_next.min_adv = 1'b0;
               if (st_reg.min_adv)
               begin
                  st_next.halted = 1'b0;
                  st_next.tm.second = 6'h00;
                  st_next.sec_cnt = 32'h0;
               end
            end
            else if (step)
            begin
               st_next.tm.minute = wdsc_step(st_reg.tm.minute, 6'h00,
                  `WDSC_MS_MAX);
               st_next.tm.second = 6'h00;
               st_next.halted = 1'b1;
               st_next.min_adv = 1'b1;
               st_next.sec_cnt = 32'h0;
            end
         end
      endcase
      st_next.pm = st_next.tm.hour >= `WDSC_PM_HOUR;
   end

   // State register.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg <= '0;
         st_reg.mode <= WDSC_V_HM;
         st_reg.tm <= {`WDSC_RST_MONTH, `WDSC_RST_DATE, `WDSC_RST_HOUR,
            `WDSC_RST_MINUTE, `WDSC_RST_SECOND};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Outputs come straight from the state flops.
   assign mode_out = st_reg.mode;
   assign time_out = st_reg.tm;
   assign pm_out = st_reg.pm;
   assign blink_out = st_reg.blink;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_hm_holds: assert property ((mode_out == WDSC_V_HM && !disp_press &&
      !set_press) |=> mode_out == WDSC_V_HM)
      else $error("Normal display left without a button press.");
   a_md_timeout: assert property ((mode_out == WDSC_V_MD && !disp_press &&
      st_reg.view_cnt == 32'(MD_CYC - 1)) |=> mode_out == WDSC_V_HM)
      else $error("Month and date view did not time out.");
   a_md_to_sec: assert property ((mode_out == WDSC_V_MD && disp_press)
      |=> mode_out == WDSC_V_SEC ##1 (mode_out == WDSC_V_SEC ||
      $past(disp_press)))
      else $error("Second press did not give a lasting seconds view.");
   a_sec_to_hm: assert property ((mode_out == WDSC_V_SEC && disp_press)
      |=> mode_out == WDSC_V_HM)
      else $error("Press in seconds view did not return to normal.");
   a_set_order: assert property (set_press |=>
      ($past(mode_out) == WDSC_V_HM) == (mode_out == WDSC_S_MON) &&
      ($past(mode_out) == WDSC_S_MON) == (mode_out == WDSC_S_DATE) &&
      ($past(mode_out) == WDSC_S_DATE) == (mode_out == WDSC_S_HOUR) &&
      ($past(mode_out) == WDSC_S_HOUR) == (mode_out == WDSC_S_MIN))
      else $error("Set sequence out of order.");
   a_press_step: assert property ((mode_out == WDSC_S_HOUR && disp_press &&
      !set_press && !sec_tick) |=> time_out.hour ==
      (($past(time_out.hour) == 5'h17) ? 5'h00 :
      $past(time_out.hour) + 5'h01))
      else $error("Single press did not step the hour by one.");
   a_auto_step: assert property ((mode_out == WDSC_S_DATE && disp_level &&
      half_tick && !set_press && !sec_tick) |=>
      time_out.date != $past(time_out.date))
      else $error("Held button did not auto step the date.");
   a_min_halts: assert property ((mode_out == WDSC_S_MIN && step &&
      !set_press) |=> st_reg.halted && time_out.second == 6'h00 ##1
      (time_out.second == 6'h00))
      else $error("Minute step did not halt with seconds at zero.");
   a_halt_zero: assert property (st_reg.halted |-> time_out.second == 6'h00
      && st_reg.sec_cnt == 32'h0)
      else $error("Seconds moved while timekeeping was halted.");
   a_resume: assert property ((mode_out == WDSC_S_MIN && set_press &&
      st_reg.min_adv) |=> !st_reg.halted && mode_out == WDSC_V_HM &&
      time_out.second == 6'h00 && st_reg.sec_cnt == 32'h0)
      else $error("Final set press did not restart from zero seconds.");
   a_keep_sec: assert property ((mode_out == WDSC_S_MIN && set_press &&
      !st_reg.min_adv && !sec_tick) |=> mode_out == WDSC_V_HM &&
      $stable(time_out.second))
      else $error("Final set press altered the seconds count.");

   c_seconds_view: cover property (mode_out == WDSC_V_MD && disp_press);
   c_auto_step: cover property (set_mode && disp_level && half_tick);
   c_resync: cover property (mode_out == WDSC_S_MIN && set_press &&
      st_reg.min_adv);

endmodule
`default_nettype wire

// file: wdsc_buttons.sv
// Model of the two user push buttons that face the watch control.
`timescale 1ns/10ps
`default_nettype none

module wdsc_buttons
#(
   parameter int DEB = 4
)
(
   input wire logic mclk,
   output var logic disp_btn,
   output var logic set_btn
);

   // Released buttons sit low, as the pull-down resistors hold them.
   initial
   begin
      disp_btn = 1'b0;
      set_btn = 1'b0;
   end

   // One press held for a given number of cycles, then a quiet gap.
   // The gap outlasts the debounce so the next press is seen as new.
   task automatic push(input bit is_set, input int hold);
      @(posedge mclk);
      #2;
      if (is_set)
         set_btn = 1'b1;
      else
         disp_btn = 1'b1;
      repeat (hold) @(posedge mclk);
      #2;
      set_btn = 1'b0;
      disp_btn = 1'b0;
      repeat (DEB + 3) @(posedge mclk);
   endtask

endmodule
`default_nettype wire

// file: wdsc_tb.sv
// Self-checking testbench of the watch display and set control.
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b, msg) begin checks++; if ((a) !== (b)) begin fail_count++; \
   $display("wrong value at %0t: %s", $time, msg); end end

module testbench;
   import wdsc_pkg::*;

   localparam int DEB = 4;
   localparam int SEC = 64;
   localparam int HALF = 16;
   localparam int MD = 100;
   localparam int LIMIT = 20000;

   logic mclk;
   logic arst_n;
   logic disp_btn;
   logic set_btn;
   wdsc_mode_t mode_out;
   wdsc_time_t tm;
   logic pm_out;
   logic blink_out;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;
   bit rst_done = 0;
   wdsc_mode_t prev_mode = WDSC_V_HM;
   wdsc_mode_t exp_q[$];

   wdsc_top #(.DEB_CYC(DEB), .SEC_CYC(SEC), .HALF_CYC(HALF), .MD_CYC(MD))
   dut_u (
      .mclk(mclk),
      .arst_n(arst_n),
      .disp_btn(disp_btn),
      .set_btn(set_btn),
      .mode_out(mode_out),
      .time_out(tm),
      .pm_out(pm_out),
      .blink_out(blink_out)
   );

   wdsc_buttons #(.DEB(DEB)) buttons_u (
      .mclk(mclk),
      .disp_btn(disp_btn),
      .set_btn(set_btn)
   );

   // Free-running 40 MHz clock.
   initial mclk = 1'b0;
   always #12.5 mclk = ~mclk;

   // Every change of the view is matched against the oldest note.
   always @(negedge mclk)
   begin
      if (rst_done && mode_out !== prev_mode)
      begin
         if (exp_q.size() == 0)
            `CHK(mode_out, prev_mode, "view changed unasked")
         else
            `CHK(mode_out, exp_q.pop_front(), "view order")
         prev_mode = mode_out;
      end
   end

   // A hang is cut short and reported as a mismatch.
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         fail_count++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (fail_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // A short press, optionally noting the view it should lead to.
   task automatic tap(input bit is_set);
      buttons_u.push(is_set, DEB + 3);
   endtask

   task automatic tap_to(input bit is_set, input wdsc_mode_t m);
      exp_q.push_back(m);
      tap(is_set);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask

   initial
   begin : main_seq
      int n;
      logic [5:0] s0;
      logic [5:0] m0;
      logic b0;
      arst_n = 1'b0;
      void'($urandom(59));
      wait_cyc(2);
      arst_n = 1'b1;
      wait_cyc(3);
      rst_done = 1;
      // Reset view and time, and a glitch shorter than the debounce.
      `CHK(mode_out, WDSC_V_HM, "reset view")
      `CHK(tm.month, 4'h1, "reset month")
      `CHK(pm_out, 1'b0, "reset pm")
      buttons_u.push(1'b0, 2);
      // Month and date for a while, set ignored, then back home.
      tap_to(1'b0, WDSC_V_MD);
      tap(1'b1);
      // The timed return to normal display is a view change of its own.
      exp_q.push_back(WDSC_V_HM);
      wait_cyc(70);
      `CHK(mode_out, WDSC_V_MD, "md view too short")
      wait_cyc(30);
      `CHK(mode_out, WDSC_V_HM, "md view no return")
      // Double press gives the seconds view, which stays put.
      tap_to(1'b0, WDSC_V_MD);
      tap_to(1'b0, WDSC_V_SEC);
      wait_cyc(3 * MD);
      `CHK(mode_out, WDSC_V_SEC, "seconds view left")
      tap_to(1'b0, WDSC_V_HM);
      // Month set: flashing, single steps, held steps and the wrap.
      tap_to(1'b1, WDSC_S_MON);
      b0 = blink_out;
      // Exactly one half period holds exactly one toggle of the flash phase.
      wait_cyc(HALF);
      `CHK(blink_out !== b0, 1'b1, "month not flashing")
      tap(1'b0);
      `CHK(tm.month, 4'h2, "month single step")
      buttons_u.push(1'b0, DEB + 2 * HALF + HALF / 2);
      `CHK(tm.month, 4'h5, "month held steps")
      repeat (8) tap(1'b0);
      `CHK(tm.month, 4'h1, "month wrap")
      // Date set.
      tap_to(1'b1, WDSC_S_DATE);
      tap(1'b0);
      `CHK(tm.date, 5'h02, "date step")
      `CHK(tm.month, 4'h1, "month kept")
      // Hour set with a random number of steps and the P indicator.
      tap_to(1'b1, WDSC_S_HOUR);
      n = 1 + ($urandom % 20);
      repeat (n) tap(1'b0);
      `CHK(tm.hour, 5'(n), "hour steps")
      `CHK(pm_out, 1'(n >= 12), "pm indicator")
      // Minute set: a step halts the count with seconds at zero.
      tap_to(1'b1, WDSC_S_MIN);
      m0 = tm.minute;
      tap(1'b0);
      `CHK(tm.minute, 6'(m0 + 1), "minute step")
      `CHK(tm.second, 6'h00, "seconds zeroed")
      wait_cyc(3 * SEC);
      `CHK(tm.second, 6'h00, "seconds ran while halted")
      `CHK(tm.minute, 6'(m0 + 1), "minute moved while halted")
      // Leaving restarts the count from zero seconds.
      tap_to(1'b1, WDSC_V_HM);
      `CHK(tm.second, 6'h00, "seconds after resume")
      wait_cyc(SEC - 20);
      `CHK(tm.second, 6'h00, "first tick too early")
      wait_cyc(30);
      `CHK(tm.second, 6'h01, "first tick missing")
      // A full set pass without a minute step keeps the seconds.
      wait_cyc(2 * SEC);
      tap_to(1'b1, WDSC_S_MON);
      tap_to(1'b1, WDSC_S_DATE);
      tap_to(1'b1, WDSC_S_HOUR);
      tap_to(1'b1, WDSC_S_MIN);
      s0 = tm.second;
      tap_to(1'b1, WDSC_V_HM);
      `CHK(tm.second == s0 || tm.second == 6'(s0 + 1), 1'b1,
         "seconds altered")
      `CHK(s0 >= 6'h02, 1'b1, "seconds not running")
      wait_cyc(4);
      `CHK(exp_q.size(), 0, "views missing")
      report_and_stop();
   end

endmodule
`default_nettype wire
